// ---- hdl/udsr_params.svh ----
`ifndef UDSR_PARAMS_SVH
`define UDSR_PARAMS_SVH

`define UDSR_ADDR_CTRL       12'h000
`define UDSR_ADDR_SOURCE     12'h004
`define UDSR_ADDR_FUNCSEL    12'h008
`define UDSR_ADDR_MINSPD     12'h00C
`define UDSR_ADDR_MAXSPD     12'h010
`define UDSR_ADDR_ACCEL      12'h014
`define UDSR_ADDR_DECEL      12'h018
`define UDSR_ADDR_SPEEDREF   12'h01C
`define UDSR_ADDR_STATUS     12'h020
`define UDSR_ADDR_IRQ_STAT   12'h024
`define UDSR_ADDR_IRQ_MASK   12'h028

`define UDSR_SRC_PLC         4'h7
`define UDSR_FN_ACCEL        5'h14
`define UDSR_FN_DECEL        5'h15

`define UDSR_CTRL_ENABLE     0
`define UDSR_CTRL_BACKUP     1

`define UDSR_RST_MINSPD      16'h0000
`define UDSR_RST_MAXSPD      16'h0708
`define UDSR_RST_RAMP        16'h0064

`define UDSR_CLK_HZ          20000000
`define UDSR_TICK_HZ         1000
`define UDSR_TICK_CYCLES     (`UDSR_CLK_HZ / `UDSR_TICK_HZ)

`define UDSR_IRQ_ACC_AL      0
`define UDSR_IRQ_DEC_AL      1
`define UDSR_IRQ_AT_MAX      2
`define UDSR_IRQ_AT_MIN      3
`define UDSR_IRQ_ZEROED      4

`endif

// ---- hdl/udsr_pkg.sv ----
package udsr_pkg;
  typedef struct packed {
    logic        enable;
    logic        backup;
    logic [3:0]  local_reference_source;
    logic [3:0]  remote_reference_source;
  } udsr_ctrl_t;

  typedef struct packed {
    logic        accel_unassigned_alarm;
    logic        decel_unassigned_alarm;
    logic        running;
    logic        accel_cmd;
    logic        decel_cmd;
  } udsr_status_t;

  typedef enum logic [2:0] {
    UDSR_HOLD  = 3'b001,
    UDSR_RAISE = 3'b010,
    UDSR_LOWER = 3'b100
  } udsr_dir_t;
endpackage

// ---- hdl/udsr_tick.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "udsr_params.svh"
module udsr_tick #(
  parameter int CYCLES = `UDSR_TICK_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  output logic      tick_out
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_q    <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (cnt_q == 32'(CYCLES - 1)) begin
      cnt_q    <= 32'h0000_0000;
      tick_out <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 32'h0000_0001;
      tick_out <= 1'b0;
    end
  end
endmodule // udsr_tick
`default_nettype wire

// ---- hdl/udsr_top.sv ----
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "udsr_params.svh"
module udsr_top #(
  parameter int TICK_CYCLES = `UDSR_TICK_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [7:0]  digital_input_n_in,
  output logic      [15:0] present_speed_reference_out,
  output logic             accel_unassigned_alarm_out,
  output logic             decel_unassigned_alarm_out,
  output logic             irq_out
);
  import udsr_pkg::*;

  udsr_ctrl_t   ctrl_q;
  udsr_status_t stat;
  udsr_dir_t    dir;
  logic [39:0]  funcsel_q;
  logic [15:0]  min_q, max_q, accel_ramp_time_q, decel_ramp_time_q;
  logic [15:0]  ref_q;
  logic [7:0]   din_s1_q, din_s2_q;
  logic [4:0]   irq_stat_q, irq_mask_q, irq_evt;
  logic         enable_prev_q, tick;
  logic         at_max_prev_q, at_min_prev_q;
  logic [7:0]   is_acc, is_dec;
  logic         acc_assigned, dec_assigned, acc_raw, dec_raw;
  logic         acc_cmd, dec_cmd, src_ok, running;
  logic [15:0]  acc_step, dec_step;
  logic [16:0]  up_sum;
  logic [15:0]  next_ref;
  logic         access, wr, rd;

  udsr_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_out   (tick)
  );

  // pin inputs pass two flops before use
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end else begin
      din_s1_q <= digital_input_n_in;
      din_s2_q <= din_s1_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_fn
      assign is_acc[gi] = (funcsel_q[gi*5 +: 5] == `UDSR_FN_ACCEL);
      assign is_dec[gi] = (funcsel_q[gi*5 +: 5] == `UDSR_FN_DECEL);
    end
  endgenerate

  // lowest-numbered assigned input wins
  always_comb begin
    acc_raw = 1'b0;
    // an unassigned decelerate input reads as its idle (high) level
    dec_raw = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      if (is_acc[i]) acc_raw = din_s2_q[i];
      if (is_dec[i]) dec_raw = din_s2_q[i];
    end
  end

  assign acc_assigned = |is_acc;
  assign dec_assigned = |is_dec;
  assign acc_cmd      = acc_raw;
  assign dec_cmd      = ~dec_raw;
  assign src_ok  = (ctrl_q.local_reference_source == `UDSR_SRC_PLC) ||
                   (ctrl_q.remote_reference_source == `UDSR_SRC_PLC);
  assign running = src_ok && acc_assigned && dec_assigned;

  always_comb begin
    if (dec_cmd) dir = UDSR_LOWER;
    else if (acc_cmd) dir = UDSR_RAISE;
    else dir = UDSR_HOLD;
  end

  // step per tick: full span over ramp time in ms
  assign acc_step = (accel_ramp_time_q == 16'h0000) ? max_q :
                    16'((max_q + accel_ramp_time_q - 16'h0001) / accel_ramp_time_q);
  assign dec_step = (decel_ramp_time_q == 16'h0000) ? max_q :
                    16'((max_q + decel_ramp_time_q - 16'h0001) / decel_ramp_time_q);
  assign up_sum = {1'b0, ref_q} + {1'b0, acc_step};

  always_comb begin
    case (dir)
      UDSR_RAISE: next_ref = (up_sum >= {1'b0, max_q}) ? max_q : up_sum[15:0];
      UDSR_LOWER: next_ref = (ref_q <= min_q + dec_step) ? min_q : ref_q - dec_step;
      UDSR_HOLD:  next_ref = ref_q;
      default:    next_ref = ref_q;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ref_q         <= 16'h0000;
      enable_prev_q <= 1'b0;
    end else begin
      enable_prev_q <= ctrl_q.enable;
      if (!running) begin
        ref_q <= ref_q;
      end else if (!ctrl_q.enable) begin
        if (acc_cmd && dec_cmd) ref_q <= 16'h0000;
      end else if (!enable_prev_q && !ctrl_q.backup) begin
        ref_q <= min_q;
      end else if (!enable_prev_q) begin
        ref_q <= (ref_q > max_q) ? max_q : ((ref_q < min_q) ? min_q : ref_q);
      end else if (tick) begin
        ref_q <= next_ref;
      end
    end
  end

  // disabled restart-from-zero then rises to the minimum on enable
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      present_speed_reference_out <= 16'h0000;
      accel_unassigned_alarm_out  <= 1'b0;
      decel_unassigned_alarm_out  <= 1'b0;
    end else begin
      present_speed_reference_out <= ref_q;
      accel_unassigned_alarm_out  <= src_ok && !acc_assigned;
      decel_unassigned_alarm_out  <= src_ok && !dec_assigned;
    end
  end

  assign stat = '{accel_unassigned_alarm: !acc_assigned, decel_unassigned_alarm: !dec_assigned,
                  running: running, accel_cmd: acc_cmd, decel_cmd: dec_cmd};

  // interrupt events: alarms, limit arrivals and the disabled zeroing
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      at_max_prev_q <= 1'b0;
      // reference resets onto the minimum, which is no arrival
      at_min_prev_q <= 1'b1;
    end else begin
      at_max_prev_q <= (ref_q == max_q);
      at_min_prev_q <= (ref_q == min_q);
    end
  end

  always_comb begin
    irq_evt = 5'h00;
    irq_evt[`UDSR_IRQ_ACC_AL] = src_ok && !acc_assigned;
    irq_evt[`UDSR_IRQ_DEC_AL] = src_ok && !dec_assigned;
    irq_evt[`UDSR_IRQ_AT_MAX] = (ref_q == max_q) && !at_max_prev_q;
    irq_evt[`UDSR_IRQ_AT_MIN] = (ref_q == min_q) && !at_min_prev_q;
    irq_evt[`UDSR_IRQ_ZEROED] = running && !ctrl_q.enable && acc_cmd && dec_cmd && (ref_q != 16'h0000);
  end

  assign access = psel_in && penable_in && pready_out;
  assign wr     = psel_in && penable_in && pwrite_in;
  assign rd     = psel_in && penable_in && !pwrite_in;

  // status clears on read; a same-cycle event wins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_stat_q <= 5'h00;
    end else if (rd && pready_out && paddr_in == `UDSR_ADDR_IRQ_STAT) begin
      irq_stat_q <= irq_evt;
    end else begin
      irq_stat_q <= irq_stat_q | irq_evt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) irq_out <= 1'b0;
    else irq_out <= |((irq_stat_q | irq_evt) & irq_mask_q);
  end

  // apb: one wait cycle, ready in the access phase's second cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) pready_out <= 1'b0;
    else pready_out <= psel_in && penable_in && !pready_out;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_q            <= '{enable: 1'b0, backup: 1'b0,
                            local_reference_source: 4'h0, remote_reference_source: 4'h0};
      funcsel_q         <= 40'h00_0000_0000;
      min_q             <= `UDSR_RST_MINSPD;
      max_q             <= `UDSR_RST_MAXSPD;
      accel_ramp_time_q <= `UDSR_RST_RAMP;
      decel_ramp_time_q <= `UDSR_RST_RAMP;
      irq_mask_q        <= 5'h00;
    end else if (wr && pready_out) begin
      case (paddr_in)
        `UDSR_ADDR_CTRL: begin
          ctrl_q.enable <= pwdata_in[`UDSR_CTRL_ENABLE];
          ctrl_q.backup <= pwdata_in[`UDSR_CTRL_BACKUP];
        end
        `UDSR_ADDR_SOURCE: begin
          ctrl_q.local_reference_source  <= pwdata_in[3:0];
          ctrl_q.remote_reference_source <= pwdata_in[7:4];
        end
        `UDSR_ADDR_FUNCSEL: funcsel_q         <= pwdata_in[0] ? {8{pwdata_in[12:8]}} :
                                                 40'(funcsel_q);
        `UDSR_ADDR_MINSPD:  min_q             <= pwdata_in[15:0];
        `UDSR_ADDR_MAXSPD:  max_q             <= pwdata_in[15:0];
        `UDSR_ADDR_ACCEL:   accel_ramp_time_q <= pwdata_in[15:0];
        `UDSR_ADDR_DECEL:   decel_ramp_time_q <= pwdata_in[15:0];
        `UDSR_ADDR_IRQ_MASK: irq_mask_q       <= pwdata_in[4:0];
        default: ;
      endcase
      // per-input select: bit0 clear writes one slot, index in bits 18:16
      if (paddr_in == `UDSR_ADDR_FUNCSEL && !pwdata_in[0])
        funcsel_q[pwdata_in[18:16]*5 +: 5] <= pwdata_in[12:8];
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (rd && !pready_out) begin
      pslverr_out <= 1'b0;
      case (paddr_in)
        `UDSR_ADDR_CTRL:     prdata_out <= {30'h0, ctrl_q.backup, ctrl_q.enable};
        `UDSR_ADDR_SOURCE:   prdata_out <= {24'h0, ctrl_q.remote_reference_source,
                                            ctrl_q.local_reference_source};
        `UDSR_ADDR_FUNCSEL:  prdata_out <= {16'h0, is_dec, is_acc};
        `UDSR_ADDR_MINSPD:   prdata_out <= {16'h0, min_q};
        `UDSR_ADDR_MAXSPD:   prdata_out <= {16'h0, max_q};
        `UDSR_ADDR_ACCEL:    prdata_out <= {16'h0, accel_ramp_time_q};
        `UDSR_ADDR_DECEL:    prdata_out <= {16'h0, decel_ramp_time_q};
        `UDSR_ADDR_SPEEDREF: prdata_out <= {16'h0, ref_q};
        `UDSR_ADDR_STATUS:   prdata_out <= {27'h0, stat};
        // include this cycle's events, the clear at ready keeps only later ones
        `UDSR_ADDR_IRQ_STAT: prdata_out <= {27'h0, irq_stat_q | irq_evt};
        `UDSR_ADDR_IRQ_MASK: prdata_out <= {27'h0, irq_mask_q};
        default: begin
          prdata_out  <= 32'h0000_0000;
          pslverr_out <= 1'b1;
        end
      endcase
    end else if (wr && !pready_out) begin
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= (paddr_in > `UDSR_ADDR_IRQ_MASK) || (paddr_in == `UDSR_ADDR_SPEEDREF) ||
                     (paddr_in == `UDSR_ADDR_STATUS) || (paddr_in == `UDSR_ADDR_IRQ_STAT) ||
                     (paddr_in[1:0] != 2'b00);
    end else if (access) begin
      pslverr_out <= 1'b0;
    end
  end
endmodule // udsr_top
`default_nettype wire

// ---- tb/udsr_contacts.sv ----
`timescale 1ns/1ns
`default_nettype none
module udsr_contacts (
  input  wire logic [7:0] press_in,
  input  wire logic [7:0] role_dec_in,
  output logic      [7:0] pins_out
);
  // decelerate contacts open when pressed, so their pin drops to 0 V
  assign pins_out = press_in ^ role_dec_in;
endmodule // udsr_contacts
`default_nettype wire

// ---- tb/udsr_top_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module udsr_props #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [15:0] present_speed_reference_out,
  input wire logic        accel_unassigned_alarm_out,
  input wire logic        decel_unassigned_alarm_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_access;
    psel_in && !penable_in ##1 psel_in && penable_in;
  endsequence
  sequence s_acc_fault;
    accel_unassigned_alarm_out [*3];
  endsequence
  a_ready_one_wait: assert property (s_access |-> !pready_out ##1 pready_out)
    else $error("pready not one cycle after access start");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held longer than one cycle");
  a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside access phase");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_err_read_zero: assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0000_0000)
    else $error("refused read returned data");
  a_reset_quiet: assert property ($fell(sys_rst_in) |-> present_speed_reference_out == 16'h0000
    && !irq_out && !accel_unassigned_alarm_out)
    else $error("outputs not cleared by reset");
  a_acc_fault_freeze: assert property (s_acc_fault |=> $stable(present_speed_reference_out))
    else $error("reference moved with accelerate unassigned");
  a_dec_fault_freeze: assert property (decel_unassigned_alarm_out [*3] |=>
    $stable(present_speed_reference_out))
    else $error("reference moved with decelerate unassigned");
  a_step_spacing: assert property ($changed(present_speed_reference_out) |=>
    $stable(present_speed_reference_out) [*2])
    else $error("reference stepped twice within one tick");
endmodule // udsr_props
bind udsr_top udsr_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clk_in, .sys_rst_in, .psel_in,
  .penable_in, .pwrite_in, .prdata_out, .pready_out, .pslverr_out, .present_speed_reference_out,
  .accel_unassigned_alarm_out, .decel_unassigned_alarm_out, .irq_out);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "udsr_params.svh"
module testbench;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        acc_al;
  logic        dec_al;
  logic        irq_out;
  logic [15:0] spd;
  logic [7:0]  pins;
  logic [7:0]  press = 8'h00;
  logic [31:0] rd;
  int          errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          n;
  always #25 clk_in = ~clk_in;
  udsr_top #(.TICK_CYCLES(4)) dut (.clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .digital_input_n_in(pins),
    .present_speed_reference_out(spd), .accel_unassigned_alarm_out(acc_al),
    .decel_unassigned_alarm_out(dec_al), .irq_out);
  udsr_contacts u_contacts (.press_in(press), .role_dec_in(8'b0010_1000), .pins_out(pins));
  task automatic test_done();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    chk({31'h0, pslverr_out}, {31'h0, e});
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 1'b0);
    chk(rd & m, e);
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic wait_ref(input logic [15:0] e, input int lo, input int hi);
    n = 0;
    while (spd !== e && n < 200) begin
      @(posedge clk_in);
      n++;
    end
    chk({16'h0, spd}, {16'h0, e});
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    idle(6);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    rdc(`UDSR_ADDR_MAXSPD, 32'hFFFF_FFFF, 32'h0000_0708);
    rdc(`UDSR_ADDR_ACCEL, 32'hFFFF_FFFF, 32'h0000_0064);
    wr(`UDSR_ADDR_IRQ_MASK, 32'h0000_0003);
    wr(`UDSR_ADDR_SOURCE, 32'h0000_0070);
    idle(4);
    chk({30'h0, acc_al, dec_al, irq_out}, 32'h7);
    rdc(`UDSR_ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0018);
    rdc(`UDSR_ADDR_IRQ_STAT, 32'h0000_000B, 32'h0000_0003);
    wr(`UDSR_ADDR_IRQ_MASK, 32'h0000_0004);
    wr(`UDSR_ADDR_SOURCE, 32'h0000_0000);
    idle(4);
    chk({30'h0, acc_al, dec_al, irq_out}, 32'h0);
    wr(`UDSR_ADDR_FUNCSEL, 32'h0002_1400);
    wr(`UDSR_ADDR_FUNCSEL, 32'h0004_1400);
    wr(`UDSR_ADDR_FUNCSEL, 32'h0003_1500);
    wr(`UDSR_ADDR_FUNCSEL, 32'h0005_1500);
    rdc(`UDSR_ADDR_FUNCSEL, 32'hFFFF_FFFF, 32'h0000_2814);
    wr(`UDSR_ADDR_MAXSPD, 32'h0000_03E8);
    wr(`UDSR_ADDR_ACCEL, 32'h0000_000A);
    wr(`UDSR_ADDR_DECEL, 32'h0000_0005);
    wr(`UDSR_ADDR_CTRL, 32'h0000_0001);
    press <= 8'h04;
    idle(20);
    chk({16'h0, spd}, 32'h0);
    press <= 8'h10;
    wr(`UDSR_ADDR_SOURCE, 32'h0000_0007);
    idle(20);
    chk({16'h0, spd}, 32'h0);
    rdc(`UDSR_ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0004);
    press <= 8'h14;
    wait_ref(16'h03E8, 36, 52);
    idle(2);
    chk({31'h0, irq_out}, 32'h1);
    press <= 8'h00;
    rdc(`UDSR_ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
    rdc(`UDSR_ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_0000);
    chk({31'h0, irq_out}, 32'h0);
    idle(20);
    rdc(`UDSR_ADDR_SPEEDREF, 32'hFFFF_FFFF, 32'h0000_03E8);
    bus(1'b1, `UDSR_ADDR_SPEEDREF, 32'h0000_0000, 1'b1);
    press <= 8'h20;
    idle(20);
    chk({16'h0, spd}, 32'h0000_03E8);
    press <= 8'h08;
    wait_ref(16'h0000, 16, 30);
    rdc(`UDSR_ADDR_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
    press <= 8'h04;
    wait_ref(16'h03E8, 36, 52);
    press <= 8'h0C;
    wait_ref(16'h0000, 16, 30);
    press <= 8'h04;
    wait_ref(16'h03E8, 36, 52);
    press <= 8'h00;
    wr(`UDSR_ADDR_CTRL, 32'h0000_0000);
    press <= 8'h08;
    idle(20);
    chk({16'h0, spd}, 32'h0000_03E8);
    press <= 8'h00;
    wr(`UDSR_ADDR_CTRL, 32'h0000_0003);
    idle(4);
    chk({16'h0, spd}, 32'h0000_03E8);
    wr(`UDSR_ADDR_CTRL, 32'h0000_0000);
    wr(`UDSR_ADDR_CTRL, 32'h0000_0001);
    idle(4);
    chk({16'h0, spd}, 32'h0000_0000);
    press <= 8'h04;
    wait_ref(16'h03E8, 36, 52);
    press <= 8'h00;
    wr(`UDSR_ADDR_CTRL, 32'h0000_0000);
    press <= 8'h0C;
    wait_ref(16'h0000, 0, 12);
    rdc(`UDSR_ADDR_IRQ_STAT, 32'h0000_0010, 32'h0000_0010);
    press <= 8'h00;
    bus(1'b0, 12'h030, 32'h0000_0000, 1'b1);
    chk(rd, 32'h0000_0000);
    test_done();
  end
endmodule // testbench
`default_nettype wire
